/* hdl/acr_cal_timer.sv */
`timescale 1ns/1ps
module acr_cal_timer
    import acr_pkg::*;
#(
    parameter int CAL0_CYC = ACR_CAL0_CYC,
    parameter int CAL1_CYC = ACR_CAL1_CYC,
    parameter int CAL2_CYC = ACR_CAL2_CYC,
    parameter int CAL3_CYC = ACR_CAL3_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic run_i,
    input wire logic [2:0] period_sel_i,
    // event
    output logic cal_request_o
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic req_q;
    logic [31:0] limit;

    // codes 4..7 carry no interval: reserved or not needed
    always_comb begin
        case (period_sel_i)
            3'h0: limit = 32'(CAL0_CYC - 1);
            3'h1: limit = 32'(CAL1_CYC - 1);
            3'h2: limit = 32'(CAL2_CYC - 1);
            3'h3: limit = 32'(CAL3_CYC - 1);
            default: limit = 32'h00000000;
        endcase
    end

    wire active = run_i && !period_sel_i[2];
    wire hit = active && (cnt_q >= limit);

    assign cnt_d = (!active || hit) ? 32'h00000000 : cnt_q + 32'h00000001;

    // interval counter, restarts when idle or after each request
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 32'h00000000;
            req_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            req_q <= hit;
        end
    end

    assign cal_request_o = req_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_no_cal_idle;
        (period_sel_i[2] || !run_i) |=> !cal_request_o;
    endproperty
    a_no_cal_idle: assert property (p_no_cal_idle) else $error("calibration with no interval selected");

endmodule

/* hdl/acr_mode_latch.sv */
`timescale 1ns/1ps
module acr_mode_latch
    import acr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // pins
    input wire logic power_good_i,
    input wire logic vref_detect_i,
    // mode
    output logic signalling_mode_flag_o,
    output logic mode_load_o
);

    logic [2:0] pg_sync_q;
    logic [2:0] vr_sync_q;
    logic pg_stable_q;
    logic vr_stable_q;
    logic mode_q;
    logic load_q;
    wire pg_agree = pg_sync_q[1] == pg_sync_q[2];
    wire vr_agree = vr_sync_q[1] == vr_sync_q[2];
    wire pg_rise = pg_agree && pg_sync_q[2] && !pg_stable_q;

    // three-stage synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pg_sync_q <= 3'h0;
            vr_sync_q <= 3'h0;
        end else begin
            pg_sync_q <= {pg_sync_q[1:0], power_good_i};
            vr_sync_q <= {vr_sync_q[1:0], vref_detect_i};
        end
    end

    // flag caught on power-good rising, held otherwise
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pg_stable_q <= 1'b0;
            vr_stable_q <= 1'b0;
            mode_q <= 1'b0;
            load_q <= 1'b0;
        end else begin
            if (pg_agree) pg_stable_q <= pg_sync_q[2];
            if (vr_agree) vr_stable_q <= vr_sync_q[2];
            load_q <= pg_rise;
            if (pg_rise) mode_q <= vr_stable_q;
        end
    end

    assign signalling_mode_flag_o = mode_q;
    assign mode_load_o = load_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_mode_hold;
        !pg_rise |=> $stable(mode_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode flag moved without power-good rise");

endmodule

/* hdl/acr_pkg.sv */
package acr_pkg;

    // ***************************************************
    // register map and layout
    // ***************************************************
    localparam logic [7:0] ACR_CMD_OFFSET = 8'hA8;
    localparam logic [31:0] ACR_CMD_WMASK = 32'h00001F17;
    localparam logic [31:0] ACR_RST_V2 = 32'h00000000;
    localparam logic [31:0] ACR_RST_V3 = 32'h00000A00;
    localparam int ACR_CAL_LSB = 10;
    localparam int ACR_SBA_BIT = 9;
    localparam int ACR_EN_BIT = 8;
    localparam int ACR_GT4G_BIT = 5;
    localparam int ACR_FW_BIT = 4;
    localparam int ACR_RATE_LSB = 0;

    // ***************************************************
    // field codes
    // ***************************************************
    localparam logic [2:0] ACR_CAL_NONE = 3'h7;
    localparam logic [2:0] ACR_RATE_B0 = 3'h1;
    localparam logic [2:0] ACR_RATE_B1 = 3'h2;
    localparam logic [2:0] ACR_RATE_B2 = 3'h4;

    // ***************************************************
    // timing
    // ***************************************************
    localparam int ACR_CLK_HZ = 20_000_000;
    localparam int ACR_CYC_PER_MS = ACR_CLK_HZ / 1000;
    localparam int ACR_CAL0_MS = 4;
    localparam int ACR_CAL1_MS = 16;
    localparam int ACR_CAL2_MS = 64;
    localparam int ACR_CAL3_MS = 256;
    localparam int ACR_CAL0_CYC = ACR_CAL0_MS * ACR_CYC_PER_MS;
    localparam int ACR_CAL1_CYC = ACR_CAL1_MS * ACR_CYC_PER_MS;
    localparam int ACR_CAL2_CYC = ACR_CAL2_MS * ACR_CYC_PER_MS;
    localparam int ACR_CAL3_CYC = ACR_CAL3_MS * ACR_CYC_PER_MS;

    // ***************************************************
    // types
    // ***************************************************
    typedef struct packed {
        logic [2:0] calibration_period_select;
        logic sideband_address_enable;
        logic port_operation_enable;
        logic fast_write_enable;
        logic [2:0] transfer_rate_select;
    } acr_cmd_t;

    typedef enum logic [1:0] {
        ACR_RATE_OFF = 2'h0,
        ACR_RATE_1X = 2'h1,
        ACR_RATE_4X = 2'h2,
        ACR_RATE_8X = 2'h3
    } acr_rate_t;

    typedef enum logic [1:0] {
        ACR_SBA_IDLE = 2'b01,
        ACR_SBA_BUSY = 2'b10
    } acr_sba_st_t;

endpackage

/* hdl/acr_top.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module acr_top
    import acr_pkg::*;
#(
    parameter int CAL0_CYC = ACR_CAL0_CYC,
    parameter int CAL1_CYC = ACR_CAL1_CYC,
    parameter int CAL2_CYC = ACR_CAL2_CYC,
    parameter int CAL3_CYC = ACR_CAL3_CYC,
    parameter int OPS_W = 6
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // board pins
    input wire logic power_good_i,
    input wire logic vref_detect_i,
    // operations from port front end
    input wire logic pipe_req_i,
    input wire logic sync_req_i,
    input wire logic sba_start_i,
    input wire logic sba_last_i,
    input wire logic op_done_i,
    output logic pipe_accept_o,
    output logic sync_accept_o,
    output logic sba_issue_o,
    output logic service_pending_o,
    // configuration out
    output logic signalling_mode_flag_o,
    output logic sideband_active_o,
    output logic [1:0] xfer_rate_o,
    output logic fast_write_active_o,
    output logic cal_request_o
);

    // ***************************************************
    // mode capture
    // ***************************************************
    logic mode_flag;
    logic mode_load;

    acr_mode_latch u_mode (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .power_good_i(power_good_i),
        .vref_detect_i(vref_detect_i),
        .signalling_mode_flag_o(mode_flag),
        .mode_load_o(mode_load)
    );

    // ***************************************************
    // command register
    // ***************************************************
    acr_cmd_t cmd_q;
    logic [31:0] rdata_q;
    wire [31:0] rst_word = mode_flag ? ACR_RST_V3 : ACR_RST_V2;
    wire hit = reg_addr_i == ACR_CMD_OFFSET;
    wire wr_hit = reg_wr_i && hit;
    wire rd_hit = reg_rd_i && hit;
    wire [31:0] wr_word = reg_wdata_i & ACR_CMD_WMASK;

    // packed view of the stored fields; bit 5 and reserved bits are zero
    wire [31:0] cmd_word = {19'h00000, cmd_q.calibration_period_select,
        cmd_q.sideband_address_enable, cmd_q.port_operation_enable,
        2'h0, 1'b0, cmd_q.fast_write_enable, 1'b0, cmd_q.transfer_rate_select};

    function automatic acr_cmd_t unpack_cmd(input logic [31:0] w);
        acr_cmd_t c;
        c.calibration_period_select = w[ACR_CAL_LSB +: 3];
        c.sideband_address_enable = w[ACR_SBA_BIT];
        c.port_operation_enable = w[ACR_EN_BIT];
        c.fast_write_enable = w[ACR_FW_BIT];
        c.transfer_rate_select = w[ACR_RATE_LSB +: 3];
        return c;
    endfunction

    // mode load reloads defaults, since the flag changes the reset image
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || mode_load) begin
            cmd_q <= unpack_cmd(rst_word);
        end else if (wr_hit) begin
            cmd_q <= unpack_cmd(wr_word);
        end
    end

    // read data valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rd_hit ? cmd_word : 32'h00000000;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ***************************************************
    // decodes
    // ***************************************************
    wire port_en = cmd_q.port_operation_enable;
    wire sba_eff = mode_flag || cmd_q.sideband_address_enable;
    wire [2:0] rsel = cmd_q.transfer_rate_select;
    acr_rate_t rate_dec;

    // unsupported and reserved codes fall to off; software keeps one bit
    always_comb begin
        rate_dec = ACR_RATE_OFF;
        if (mode_flag) begin
            if (rsel == ACR_RATE_B0) rate_dec = ACR_RATE_4X;
            else if (rsel == ACR_RATE_B1) rate_dec = ACR_RATE_8X;
        end else begin
            if (rsel == ACR_RATE_B0) rate_dec = ACR_RATE_1X;
            else if (rsel == ACR_RATE_B2) rate_dec = ACR_RATE_4X;
        end
    end

    // fast write needs enable and a rate above 1X; else PCI protocol
    wire fw_dec = cmd_q.fast_write_enable && (rate_dec == ACR_RATE_4X || rate_dec == ACR_RATE_8X);
    wire is_1x = rate_dec == ACR_RATE_1X;

    logic sba_act_q;
    logic [1:0] rate_q;
    logic fw_q;

    // registered copies for the port logic
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sba_act_q <= 1'b0;
            rate_q <= ACR_RATE_OFF;
            fw_q <= 1'b0;
        end else begin
            sba_act_q <= sba_eff;
            rate_q <= rate_dec;
            fw_q <= fw_dec;
        end
    end

    assign signalling_mode_flag_o = mode_flag;
    assign sideband_active_o = sba_act_q;
    assign xfer_rate_o = rate_q;
    assign fast_write_active_o = fw_q;

    // ***************************************************
    // operation gating
    // ***************************************************
    acr_sba_st_t sba_st_q;
    acr_sba_st_t sba_st_d;
    wire sba_take = sba_start_i && port_en && sba_eff;

    assign pipe_accept_o = pipe_req_i && port_en;
    assign sync_accept_o = sync_req_i && port_en;

    // 1X commands span cycles; once begun they finish regardless of enable
    always_comb begin
        sba_st_d = sba_st_q;
        sba_issue_o = 1'b0;
        case (sba_st_q)
            ACR_SBA_IDLE: begin
                if (sba_take) begin
                    if (is_1x && !sba_last_i) sba_st_d = ACR_SBA_BUSY;
                    else sba_issue_o = 1'b1;
                end
            end
            ACR_SBA_BUSY: begin
                if (sba_last_i) begin
                    sba_issue_o = 1'b1;
                    sba_st_d = ACR_SBA_IDLE;
                end
            end
            default: sba_st_d = ACR_SBA_IDLE;
        endcase
    end

    // sideband state register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) sba_st_q <= ACR_SBA_IDLE;
        else sba_st_q <= sba_st_d;
    end

    // outstanding count; completions never gated by the enable
    logic [OPS_W-1:0] ops_q;
    wire op_in = pipe_accept_o || sba_issue_o;
    wire op_out = op_done_i && (ops_q != '0);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ops_q <= '0;
        end else if (op_in && !op_out) begin
            ops_q <= ops_q + OPS_W'(1);
        end else if (op_out && !op_in) begin
            ops_q <= ops_q - OPS_W'(1);
        end
    end

    assign service_pending_o = ops_q != '0;

    // ***************************************************
    // calibration timer
    // ***************************************************
    acr_cal_timer #(
        .CAL0_CYC(CAL0_CYC),
        .CAL1_CYC(CAL1_CYC),
        .CAL2_CYC(CAL2_CYC),
        .CAL3_CYC(CAL3_CYC)
    ) u_cal (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(port_en),
        .period_sel_i(cmd_q.calibration_period_select),
        .cal_request_o(cal_request_o)
    );

    // ***************************************************
    // checks
    // ***************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_sba_begin_1x;
        sba_st_q == ACR_SBA_IDLE && sba_take && is_1x && !sba_last_i;
    endsequence

    property p_rd_reserved;
        reg_rd_i |=> (reg_rdata_o & ~ACR_CMD_WMASK) == 32'h00000000;
    endproperty
    a_rd_reserved: assert property (p_rd_reserved) else $error("reserved or bit 5 read nonzero");

    property p_wr_readback;
        (wr_hit && !mode_load) ##1 rd_hit |=> reg_rdata_o == ($past(reg_wdata_i, 2) & ACR_CMD_WMASK);
    endproperty
    a_wr_readback: assert property (p_wr_readback) else $error("written value not read back");

    property p_reset_image;
        $rose(rst_n_i) |-> cmd_word == (mode_flag ? ACR_RST_V3 : ACR_RST_V2);
    endproperty
    a_reset_image: assert property (p_reset_image) else $error("reset image wrong for mode");

    property p_disabled_ignore;
        !port_en |-> !pipe_accept_o && !sync_accept_o && !(sba_st_q == ACR_SBA_IDLE && sba_issue_o);
    endproperty
    a_disabled_ignore: assert property (p_disabled_ignore) else $error("operation taken while disabled");

    property p_sba_needs_enable;
        (sba_st_q == ACR_SBA_IDLE && sba_issue_o) |-> sba_eff;
    endproperty
    a_sba_needs_enable: assert property (p_sba_needs_enable) else $error("sideband taken with sideband off");

    property p_mode3_sideband;
        mode_flag |=> sideband_active_o;
    endproperty
    a_mode3_sideband: assert property (p_mode3_sideband) else $error("sideband off in newer mode");

    property p_sba_finish;
        s_sba_begin_1x ##1 (sba_last_i && !port_en) |-> sba_issue_o;
    endproperty
    a_sba_finish: assert property (p_sba_finish) else $error("1X sideband command dropped");

    property p_pci_on_1x;
        (is_1x || !cmd_q.fast_write_enable) |=> !fast_write_active_o;
    endproperty
    a_pci_on_1x: assert property (p_pci_on_1x) else $error("fast write with 1X or disabled");

    property p_fw_rate;
        (cmd_q.fast_write_enable && mode_flag && rsel == ACR_RATE_B1)
            |=> fast_write_active_o && xfer_rate_o == ACR_RATE_8X;
    endproperty
    a_fw_rate: assert property (p_fw_rate) else $error("fast write rate wrong");

    property p_old_decode;
        (!mode_flag && rsel == ACR_RATE_B2) |=> xfer_rate_o == ACR_RATE_4X;
    endproperty
    a_old_decode: assert property (p_old_decode) else $error("older mode 4X decode wrong");

    property p_pending_hold;
        (service_pending_o && !op_done_i) |=> service_pending_o;
    endproperty
    a_pending_hold: assert property (p_pending_hold) else $error("pending work lost");

endmodule

/* testbench/acr_agp_master_model.sv */
`timescale 1ns/1ps
// ****************************************
// far-side graphics master offering port operations
// ****************************************
module acr_agp_master_model (
    // clock
    input wire logic ref_clk_i,
    // answers from the port
    input wire logic pipe_accept_i,
    input wire logic sync_accept_i,
    input wire logic sba_issue_i,
    // operations offered
    output logic pipe_req_o,
    output logic sync_req_o,
    output logic sba_start_o,
    output logic sba_last_o,
    output logic op_done_o
);
    // quiet until the bench asks for traffic
    initial begin
        {pipe_req_o, sync_req_o, sba_start_o, sba_last_o, op_done_o} = 5'h00;
    end

    // one-cycle pipe (0), sync (1) or done (2); answer taken at the closing edge
    task automatic pulse(input int kind, output logic seen);
        @(posedge ref_clk_i);
        pipe_req_o <= (kind == 0);
        sync_req_o <= (kind == 1);
        op_done_o <= (kind == 2);
        @(posedge ref_clk_i);
        seen = (kind == 0) ? pipe_accept_i : sync_accept_i;
        {pipe_req_o, sync_req_o, op_done_o} <= 3'h0;
    endtask

    // sideband command of len cycles, always closed by its last marker
    task automatic sba(input int len, output logic seen);
        @(posedge ref_clk_i);
        sba_start_o <= 1'b1;
        sba_last_o <= (len == 1);
        for (int i = 1; i < len; i++) begin
            @(posedge ref_clk_i);
            sba_start_o <= 1'b0;
            sba_last_o <= (i == len - 1);
        end
        // issue stands in the last cycle of a 1X or one-cycle command, else in the first; take it at the edge closing the last
        @(posedge ref_clk_i);
        seen = sba_issue_i;
        sba_start_o <= 1'b0;
        sba_last_o <= 1'b0;
    endtask
endmodule

/* testbench/acr_top_test.sv */
`timescale 1ns/1ps
module acr_top_test;
    import acr_pkg::*;
    typedef struct {logic m; logic [31:0] wd; logic [31:0] rd; logic [1:0] rate; logic fw; logic sb;} acr_row_t;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h00000000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic power_good_i = 1'b0;
    logic vref_detect_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic pipe_req, sync_req, sba_start, sba_last, op_done;
    logic pipe_accept_o, sync_accept_o, sba_issue_o, service_pending_o;
    logic signalling_mode_flag_o, sideband_active_o, fast_write_active_o, cal_request_o;
    logic [1:0] xfer_rate_o;
    logic seen;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    int gap;
    int cal_cyc[4] = '{8, 16, 32, 64};
    // ****************************************
    // ordinary cases: mode, write, readback, decoded outputs
    // ****************************************
    acr_row_t rows[8] = '{
        '{1'b0, 32'hFFFFFFF9, 32'h00001F11, 2'h1, 1'b0, 1'b1},
        '{1'b0, 32'h00000301, 32'h00000301, 2'h1, 1'b0, 1'b1},
        '{1'b0, 32'h00000014, 32'h00000014, 2'h2, 1'b1, 1'b0},
        '{1'b0, 32'h00000011, 32'h00000011, 2'h1, 1'b0, 1'b0},
        '{1'b0, 32'h000000E2, 32'h00000002, 2'h0, 1'b0, 1'b0},
        '{1'b1, 32'h00000001, 32'h00000001, 2'h2, 1'b0, 1'b1},
        '{1'b1, 32'h00000012, 32'h00000012, 2'h3, 1'b1, 1'b1},
        '{1'b1, 32'h00000014, 32'h00000014, 2'h0, 1'b0, 1'b1}
    };

    acr_top #(.CAL0_CYC(8), .CAL1_CYC(16), .CAL2_CYC(32), .CAL3_CYC(64)) acr_top_i (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .power_good_i(power_good_i),
        .vref_detect_i(vref_detect_i), .pipe_req_i(pipe_req), .sync_req_i(sync_req), .sba_start_i(sba_start),
        .sba_last_i(sba_last), .op_done_i(op_done), .pipe_accept_o(pipe_accept_o), .sync_accept_o(sync_accept_o),
        .sba_issue_o(sba_issue_o), .service_pending_o(service_pending_o),
        .signalling_mode_flag_o(signalling_mode_flag_o), .sideband_active_o(sideband_active_o),
        .xfer_rate_o(xfer_rate_o), .fast_write_active_o(fast_write_active_o), .cal_request_o(cal_request_o));

    acr_agp_master_model acr_agp_master_model_i (
        .ref_clk_i(ref_clk_i), .pipe_accept_i(pipe_accept_o), .sync_accept_i(sync_accept_o),
        .sba_issue_i(sba_issue_o), .pipe_req_o(pipe_req), .sync_req_o(sync_req), .sba_start_o(sba_start),
        .sba_last_o(sba_last), .op_done_o(op_done));

    // clock and hang guard; whole run is under a thousand cycles
    always #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles >= 20000) begin
            failures++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // write then read with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("read back", exp, reg_rdata_o);
    endtask

    // read data stands one cycle only, then must drop to zero
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("read data", exp, reg_rdata_o);
        @(posedge ref_clk_i);
        #1 chk("read data after", 32'h0, reg_rdata_o);
    endtask

    // power good drop and rise; the mode is caught on the rise
    task automatic set_mode(input logic m);
        @(posedge ref_clk_i);
        power_good_i <= 1'b0;
        vref_detect_i <= m;
        repeat (6) @(posedge ref_clk_i);
        power_good_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        #1 chk("mode flag", {31'h0, m}, {31'h0, signalling_mode_flag_o});
        rd(ACR_CMD_OFFSET, m ? ACR_RST_V3 : ACR_RST_V2);
    endtask

    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        set_mode(1'b0);
        foreach (rows[i]) begin
            if (signalling_mode_flag_o !== rows[i].m) set_mode(rows[i].m);
            wr_rd(ACR_CMD_OFFSET, rows[i].wd, rows[i].rd);
            rd(ACR_CMD_OFFSET, rows[i].rd);
            chk("rate", {30'h0, rows[i].rate}, {30'h0, xfer_rate_o});
            chk("fast write", {31'h0, rows[i].fw}, {31'h0, fast_write_active_o});
            chk("sideband", {31'h0, rows[i].sb}, {31'h0, sideband_active_o});
        end
        // ****************************************
        // awkward cases
        // ****************************************
        wr(ACR_CMD_OFFSET, 32'h00000101);
        acr_agp_master_model_i.sba(1, seen);
        chk("sba newer mode", 32'h1, {31'h0, seen});
        set_mode(1'b0);
        wr(ACR_CMD_OFFSET, 32'h00000101);
        acr_agp_master_model_i.sba(1, seen);
        chk("sba not enabled", 32'h0, {31'h0, seen});
        acr_agp_master_model_i.pulse(0, seen);
        chk("pipe enabled", 32'h1, {31'h0, seen});
        acr_agp_master_model_i.pulse(1, seen);
        chk("sync enabled", 32'h1, {31'h0, seen});
        wr(ACR_CMD_OFFSET, 32'h00000201);
        acr_agp_master_model_i.pulse(0, seen);
        chk("pipe disabled", 32'h0, {31'h0, seen});
        acr_agp_master_model_i.pulse(1, seen);
        chk("sync disabled", 32'h0, {31'h0, seen});
        acr_agp_master_model_i.sba(1, seen);
        chk("sba disabled", 32'h0, {31'h0, seen});
        // unmapped place must not alias the register
        wr(8'hAC, 32'hFFFFFFFF);
        rd(8'hAC, 32'h0);
        rd(ACR_CMD_OFFSET, 32'h00000201);
        // mid-run reset drops the mode and the pending count
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd(ACR_CMD_OFFSET, ACR_RST_V2);
        chk("pending after reset", 32'h0, {31'h0, service_pending_o});
        // power good is still high, so the mode reload follows release; a write then would be lost
        repeat (4) @(posedge ref_clk_i);
        // enable falls in the middle of a 1X sideband command
        wr(ACR_CMD_OFFSET, 32'h00000301);
        fork
            acr_agp_master_model_i.sba(2, seen);
            wr(ACR_CMD_OFFSET, 32'h00000001);
        join
        chk("sba late issue", 32'h1, {31'h0, seen});
        #1 chk("pending", 32'h1, {31'h0, service_pending_o});
        acr_agp_master_model_i.pulse(2, seen);
        #1 chk("pending done", 32'h0, {31'h0, service_pending_o});
        // calibration interval per code, scaled counts
        for (int c = 0; c < 4; c++) begin
            wr(ACR_CMD_OFFSET, 32'h00000101 | (c << 10));
            #1 gap = 0; // look once the edge settles, so a stale pulse still marks a restart
            while (cal_request_o !== 1'b1 && gap < 300) begin
                @(posedge ref_clk_i);
                #1 gap++;
            end
            gap = 0;
            do begin
                @(posedge ref_clk_i);
                #1 gap++;
            end while (cal_request_o !== 1'b1 && gap < 300);
            chk("cal gap", cal_cyc[c], gap);
        end
        wr(ACR_CMD_OFFSET, 32'h00001D01);
        gap = 0;
        repeat (150) begin
            @(posedge ref_clk_i);
            #1 if (cal_request_o === 1'b1) gap++;
        end
        chk("cal none", 32'h0, gap);
        summarize();
    end
endmodule
